// [hdl/psr_pkg.sv]
// Package: register map, field positions, reset values and carriers of the PHY status block
package psr_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_AN_EXP = 10'h006;
  localparam logic [9:0] IDX_FUNC_CTRL = 10'h010;
  localparam logic [9:0] IDX_PHY_STAT = 10'h011;
  localparam logic [9:0] IDX_IRQ_EN = 10'h012;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h013;
  localparam logic [9:0] IDX_SOFT_RST = 10'h01F;

  // Expansion register fields
  localparam int EXP_PDF = 4;
  localparam int EXP_RSVD_RW = 2;
  localparam int EXP_PAGE = 1;
  localparam int EXP_LP_ABLE = 0;
  localparam logic EXP_RSVD_RW_RST = 1'b1;

  // Function control fields
  localparam int FC_CRS = 11;
  localparam int FC_ED_HI = 9;
  localparam int FC_ED_LO = 8;
  localparam int FC_MDI_HI = 6;
  localparam int FC_MDI_LO = 5;
  localparam int FC_SQE = 2;
  localparam int FC_POL_DIS = 1;
  localparam int FC_JAB_DIS = 0;
  localparam logic [15:0] FC_WMASK = 16'h0B67;
  localparam logic [1:0] FC_MDI_RST = 2'h3;
  localparam logic [1:0] FC_ED_RST = 2'h0;

  // Status fields
  localparam int ST_SPD_HI = 15;
  localparam int ST_SPD_LO = 14;
  localparam int ST_DUP = 13;
  localparam int ST_PAGE = 12;
  localparam int ST_RES = 11;
  localparam int ST_LINK = 10;
  localparam int ST_MDIX = 6;
  localparam int ST_DOWN = 5;
  localparam int ST_ED = 4;
  localparam int ST_TXP = 3;
  localparam int ST_RXP = 2;
  localparam int ST_POL = 1;
  localparam int ST_JAB = 0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_10 = 2'h0;

  // Interrupt enable and status
  localparam logic [15:0] IE_WMASK = 16'hFFF3;
  localparam logic [15:0] IE_RST = 16'h0000;
  localparam int IS_AN_ERR = 15;
  localparam int IS_SPD_CHG = 14;
  localparam int IS_DUP_CHG = 13;
  localparam int IS_PAGE = 12;
  localparam int IS_AN_DONE = 11;

  localparam int SOFT_RST_BIT = 0;

  typedef enum logic [1:0] {
    MDI_MANUAL = 2'b00,
    MDIX_MANUAL = 2'b01,
    MDI_RSVD = 2'b10,
    MDI_AUTO = 2'b11
  } psr_mdi_e;

  // Live indications from the PHY datapath and negotiation logic
  typedef struct packed {
    logic par_det_fault;
    logic page_rx;
    logic lp_an_able;
    logic an_complete;
    logic an_disabled;
    logic speed_100;
    logic full_duplex;
    logic page_live;
    logic link_up;
    logic mdix_auto;
    logic tx_pause;
    logic rx_pause;
    logic ed_sleep;
    logic downgrade;
    logic pol_reversed;
    logic jabber;
    logic no_common_ability;
  } psr_phy_stat_s;

  // Controls applied to the PHY datapath
  typedef struct packed {
    logic crs_on_tx;
    logic ed_sense_en;
    logic nlp_tx_en;
    logic [1:0] mdi_mode;
    logic sqe_test_en;
    logic pol_correct_en;
    logic jabber_en;
    logic soft_rst;
  } psr_phy_ctrl_s;

endpackage

// [hdl/psr_phy_status_irq_regs.sv]
// PHY management register subset: expansion, function control, status, interrupt enable and status
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module psr_phy_status_irq_regs (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [psr_pkg::ADDR_W-1:0] PADDR,
  input wire logic [psr_pkg::DATA_W-1:0] PWDATA,
  output logic [psr_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire psr_pkg::psr_phy_stat_s PHY_STAT,
  output psr_pkg::psr_phy_ctrl_s PHY_CTRL,
  output logic IRQ
);

  function automatic logic hit(input logic [psr_pkg::ADDR_W-1:0] addr, input logic [9:0] idx);
    hit = (addr[1:0] == 2'h0) && (addr[psr_pkg::ADDR_W-1:2] == idx);
  endfunction

  // Expansion register
  logic exp_pdf;
  logic exp_page;
  logic exp_lp_able;
  logic exp_rsvd;
  // Function control
  logic fc_crs;
  logic [1:0] fc_ed;
  logic [1:0] fc_mdi;
  logic [1:0] mdi_applied;
  logic fc_sqe;
  logic fc_pol_dis;
  logic fc_jab_dis;
  // Status
  logic [1:0] st_speed;
  logic st_dup;
  logic st_page;
  logic st_res;
  logic st_link;
  logic st_mdix;
  logic st_down;
  logic st_ed;
  logic st_txp;
  logic st_rxp;
  logic st_pol;
  logic st_jab;
  logic link_prev;
  // Interrupts
  logic [15:0] irq_en;
  logic is_an_err;
  logic is_spd_chg;
  logic is_dup_chg;
  logic is_page;
  logic is_an_done;
  // Bus
  logic soft_rst;
  logic [15:0] rd_word;

  logic access;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic resolved_now;
  logic [1:0] next_speed;
  logic an_err_evt;
  logic spd_chg_evt;
  logic dup_chg_evt;
  logic [15:0] exp_word;
  logic [15:0] fc_word;
  logic [15:0] st_word;
  logic [15:0] is_word;

  assign access = PSEL && PENABLE && PREADY;
  assign wr_en = access && PWRITE;
  assign rd_en = access && !PWRITE;
  assign mapped = hit(PADDR, psr_pkg::IDX_AN_EXP) || hit(PADDR, psr_pkg::IDX_FUNC_CTRL) ||
                  hit(PADDR, psr_pkg::IDX_PHY_STAT) || hit(PADDR, psr_pkg::IDX_IRQ_EN) ||
                  hit(PADDR, psr_pkg::IDX_IRQ_STAT) || hit(PADDR, psr_pkg::IDX_SOFT_RST);

  assign resolved_now = PHY_STAT.an_complete || PHY_STAT.an_disabled;
  assign next_speed = PHY_STAT.speed_100 ? psr_pkg::SPD_100 : psr_pkg::SPD_10;
  assign an_err_evt = PHY_STAT.par_det_fault || PHY_STAT.no_common_ability ||
                      (is_an_done && link_prev && !PHY_STAT.link_up);
  assign spd_chg_evt = resolved_now && st_res && (next_speed != st_speed);
  assign dup_chg_evt = resolved_now && st_res && (PHY_STAT.full_duplex != st_dup);

  always_comb begin
    exp_word = 16'h0000;
    exp_word[psr_pkg::EXP_PDF] = exp_pdf;
    exp_word[psr_pkg::EXP_RSVD_RW] = exp_rsvd;
    exp_word[psr_pkg::EXP_PAGE] = exp_page;
    exp_word[psr_pkg::EXP_LP_ABLE] = exp_lp_able;
  end

  always_comb begin
    fc_word = 16'h0000;
    fc_word[psr_pkg::FC_CRS] = fc_crs;
    fc_word[psr_pkg::FC_ED_HI:psr_pkg::FC_ED_LO] = fc_ed;
    fc_word[psr_pkg::FC_MDI_HI:psr_pkg::FC_MDI_LO] = fc_mdi;
    fc_word[psr_pkg::FC_SQE] = fc_sqe;
    fc_word[psr_pkg::FC_POL_DIS] = fc_pol_dis;
    fc_word[psr_pkg::FC_JAB_DIS] = fc_jab_dis;
  end

  always_comb begin
    st_word = 16'h0000;
    st_word[psr_pkg::ST_SPD_HI:psr_pkg::ST_SPD_LO] = st_speed;
    st_word[psr_pkg::ST_DUP] = st_dup;
    st_word[psr_pkg::ST_PAGE] = st_page;
    st_word[psr_pkg::ST_RES] = st_res;
    st_word[psr_pkg::ST_LINK] = st_link;
    st_word[psr_pkg::ST_MDIX] = st_mdix;
    st_word[psr_pkg::ST_DOWN] = st_down;
    st_word[psr_pkg::ST_ED] = st_ed;
    st_word[psr_pkg::ST_TXP] = st_txp;
    st_word[psr_pkg::ST_RXP] = st_rxp;
    st_word[psr_pkg::ST_POL] = st_pol;
    st_word[psr_pkg::ST_JAB] = st_jab;
  end

  always_comb begin
    is_word = 16'h0000;
    is_word[psr_pkg::IS_AN_ERR] = is_an_err;
    is_word[psr_pkg::IS_SPD_CHG] = is_spd_chg;
    is_word[psr_pkg::IS_DUP_CHG] = is_dup_chg;
    is_word[psr_pkg::IS_PAGE] = is_page;
    is_word[psr_pkg::IS_AN_DONE] = is_an_done;
  end

  always_comb begin
    rd_word = 16'h0000;
    if (hit(PADDR, psr_pkg::IDX_AN_EXP)) begin
      rd_word = exp_word;
    end else if (hit(PADDR, psr_pkg::IDX_FUNC_CTRL)) begin
      rd_word = fc_word;
    end else if (hit(PADDR, psr_pkg::IDX_PHY_STAT)) begin
      rd_word = st_word;
    end else if (hit(PADDR, psr_pkg::IDX_IRQ_EN)) begin
      rd_word = irq_en;
    end else if (hit(PADDR, psr_pkg::IDX_IRQ_STAT)) begin
      rd_word = is_word;
    end
  end

  // APB: ready in the first access cycle; data and response are captured in the setup cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      if (PSEL && !PENABLE) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : {16'h0000, rd_word};
        PSLVERR <= !mapped;
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // Software reset strobe, one cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_en && hit(PADDR, psr_pkg::IDX_SOFT_RST) && PWDATA[psr_pkg::SOFT_RST_BIT];
    end
  end

  // Expansion register
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      exp_pdf <= 1'b0;
      exp_page <= 1'b0;
      exp_lp_able <= 1'b0;
      exp_rsvd <= psr_pkg::EXP_RSVD_RW_RST;
    end else if (soft_rst) begin
      exp_pdf <= 1'b0;
      exp_page <= 1'b0;
      exp_lp_able <= 1'b0;
      exp_rsvd <= psr_pkg::EXP_RSVD_RW_RST;
    end else begin
      exp_lp_able <= PHY_STAT.lp_an_able;
      if (PHY_STAT.par_det_fault) begin
        exp_pdf <= 1'b1;
      end else if (rd_en && hit(PADDR, psr_pkg::IDX_AN_EXP)) begin
        exp_pdf <= 1'b0;
      end
      if (PHY_STAT.page_rx) begin
        exp_page <= 1'b1;
      end else if (rd_en && hit(PADDR, psr_pkg::IDX_AN_EXP)) begin
        exp_page <= 1'b0;
      end
      if (wr_en && hit(PADDR, psr_pkg::IDX_AN_EXP)) begin
        exp_rsvd <= PWDATA[psr_pkg::EXP_RSVD_RW];
      end
    end
  end

  // Function control; all fields keep their value across software reset
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fc_crs <= 1'b0;
      fc_ed <= psr_pkg::FC_ED_RST;
      fc_mdi <= psr_pkg::FC_MDI_RST;
      fc_sqe <= 1'b0;
      fc_pol_dis <= 1'b0;
      fc_jab_dis <= 1'b0;
    end else if (wr_en && hit(PADDR, psr_pkg::IDX_FUNC_CTRL)) begin
      fc_crs <= PWDATA[psr_pkg::FC_CRS];
      fc_ed <= PWDATA[psr_pkg::FC_ED_HI:psr_pkg::FC_ED_LO];
      fc_mdi <= PWDATA[psr_pkg::FC_MDI_HI:psr_pkg::FC_MDI_LO];
      fc_sqe <= PWDATA[psr_pkg::FC_SQE];
      fc_pol_dis <= PWDATA[psr_pkg::FC_POL_DIS];
      fc_jab_dis <= PWDATA[psr_pkg::FC_JAB_DIS];
    end
  end

  // Crossover mode in use by the datapath changes only at software reset or hardware reset
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mdi_applied <= psr_pkg::FC_MDI_RST;
    end else if (soft_rst) begin
      mdi_applied <= fc_mdi;
    end
  end

  // Status register
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_speed <= psr_pkg::SPD_10;
      st_dup <= 1'b0;
      st_page <= 1'b0;
      st_res <= 1'b0;
      st_link <= 1'b0;
      st_mdix <= 1'b0;
      st_down <= 1'b0;
      st_ed <= 1'b0;
      st_txp <= 1'b0;
      st_rxp <= 1'b0;
      st_pol <= 1'b0;
      st_jab <= 1'b0;
    end else if (soft_rst) begin
      st_res <= 1'b0;
      st_link <= 1'b0;
      st_down <= 1'b0;
      st_ed <= 1'b0;
      st_pol <= 1'b0;
    end else begin
      st_res <= resolved_now;
      if (resolved_now) begin
        st_speed <= next_speed;
        st_dup <= PHY_STAT.full_duplex;
        st_txp <= PHY_STAT.tx_pause;
        st_rxp <= PHY_STAT.rx_pause;
        if (mdi_applied == psr_pkg::MDI_AUTO) begin
          st_mdix <= PHY_STAT.mdix_auto;
        end else begin
          st_mdix <= mdi_applied[0];
        end
      end
      st_page <= PHY_STAT.page_live;
      st_link <= PHY_STAT.link_up;
      st_ed <= PHY_STAT.ed_sleep;
      if (PHY_STAT.downgrade) begin
        st_down <= 1'b1;
      end
      st_pol <= PHY_STAT.pol_reversed;
      st_jab <= PHY_STAT.jabber;
    end
  end

  // Interrupt enables, untouched by software reset
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_en <= psr_pkg::IE_RST;
    end else if (wr_en && hit(PADDR, psr_pkg::IDX_IRQ_EN)) begin
      irq_en <= PWDATA[15:0] & psr_pkg::IE_WMASK;
    end
  end

  // Interrupt status; untouched by software reset, latched bits clear on a read or on hardware reset
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      is_an_err <= 1'b0;
      is_spd_chg <= 1'b0;
      is_dup_chg <= 1'b0;
      is_page <= 1'b0;
      is_an_done <= 1'b0;
      link_prev <= 1'b0;
    end else begin
      link_prev <= PHY_STAT.link_up;
      is_page <= PHY_STAT.page_live;
      is_an_done <= PHY_STAT.an_complete;
      if (an_err_evt) begin
        is_an_err <= 1'b1;
      end else if (rd_en && hit(PADDR, psr_pkg::IDX_IRQ_STAT)) begin
        is_an_err <= 1'b0;
      end
      if (spd_chg_evt) begin
        is_spd_chg <= 1'b1;
      end else if (rd_en && hit(PADDR, psr_pkg::IDX_IRQ_STAT)) begin
        is_spd_chg <= 1'b0;
      end
      if (dup_chg_evt) begin
        is_dup_chg <= 1'b1;
      end else if (rd_en && hit(PADDR, psr_pkg::IDX_IRQ_STAT)) begin
        is_dup_chg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(is_word & irq_en);
    end
  end

  // Controls to the datapath; pause bits are deliberately not used here
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PHY_CTRL <= '0;
      PHY_CTRL.mdi_mode <= psr_pkg::FC_MDI_RST;
    end else begin
      PHY_CTRL.crs_on_tx <= fc_crs;
      PHY_CTRL.ed_sense_en <= fc_ed[1];
      PHY_CTRL.nlp_tx_en <= fc_ed[1] && fc_ed[0];
      PHY_CTRL.mdi_mode <= mdi_applied;
      PHY_CTRL.sqe_test_en <= fc_sqe && !st_dup;
      PHY_CTRL.pol_correct_en <= !fc_pol_dis;
      PHY_CTRL.jabber_en <= !fc_jab_dis && (st_speed == psr_pkg::SPD_10) && !st_dup;
      PHY_CTRL.soft_rst <= soft_rst;
    end
  end

endmodule

// [tb/psr_phy_status_irq_regs_sva.sv]
// Port-level checker for the PHY status and interrupt register block
`timescale 1ns/100ps
module psr_phy_status_irq_regs_sva (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [psr_pkg::ADDR_W-1:0] PADDR,
  input wire logic [psr_pkg::DATA_W-1:0] PWDATA,
  input wire logic [psr_pkg::DATA_W-1:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire psr_pkg::psr_phy_stat_s PHY_STAT,
  input wire psr_pkg::psr_phy_ctrl_s PHY_CTRL,
  input wire logic IRQ
);
  default clocking dcb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  logic rd_acc;
  logic wr_done;
  logic sr_wr;
  assign rd_acc = PSEL && PENABLE && !PWRITE;
  assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
  assign sr_wr = wr_done && PADDR == 12'h07C && PWDATA[0];
  sequence exp_rd;
    rd_acc && PADDR == 12'h018;
  endsequence
  sequence no_event;
    (!PHY_STAT.par_det_fault && !PHY_STAT.page_rx)[*3];
  endsequence
  sequence fc_wr;
    wr_done && PADDR == 12'h040;
  endsequence
  AST_PDF_LATCH: assert property (PHY_STAT.par_det_fault ##4 exp_rd |-> PRDATA[4])
    else $error("fault flag missed");
  AST_LATCH_CLR: assert property (no_event ##0 exp_rd ##1 no_event ##0 exp_rd |-> !PRDATA[4] && !PRDATA[1])
    else $error("latched flag kept after read");
  AST_SPEED: assert property ((PHY_STAT.an_complete && PHY_STAT.speed_100 && !sr_wr)[*6] ##0 rd_acc
    && PADDR == 12'h044 |-> PRDATA[15:13] == 3'h2 || PRDATA[15:13] == 3'h3)
    else $error("speed code wrong");
  AST_DONE: assert property ((PHY_STAT.an_complete && !sr_wr)[*6] ##0 rd_acc && PADDR == 12'h04C |-> PRDATA[11])
    else $error("completion bit low");
  AST_SQE: assert property ((PHY_STAT.an_complete && PHY_STAT.full_duplex)[*4] |-> !PHY_CTRL.sqe_test_en)
    else $error("sqe test in full duplex");
  AST_POL: assert property (fc_wr |-> ##2 PHY_CTRL.pol_correct_en == !$past(PWDATA[1], 2))
    else $error("polarity control wrong");
  AST_ED: assert property (fc_wr |-> ##2 PHY_CTRL.ed_sense_en == $past(PWDATA[9], 2)
    && PHY_CTRL.nlp_tx_en == ($past(PWDATA[9:8], 2) == 2'h3))
    else $error("energy detect mode wrong");
  AST_MDI: assert property ($changed(PHY_CTRL.mdi_mode) |-> $past(sr_wr, 1) || $past(sr_wr, 2)
    || $past(sr_wr, 3) || $past(sr_wr, 4))
    else $error("crossover changed without soft reset");
  AST_IRQ_OFF: assert property (rd_acc && PADDR == 12'h048 && PRDATA[15:11] == 5'h00 |=> !IRQ)
    else $error("interrupt with no enable");
  sequence srst_pulse;
    PHY_CTRL.soft_rst ##1 !PHY_CTRL.soft_rst;
  endsequence
  AST_SRST: assert property (sr_wr |-> ##2 srst_pulse)
    else $error("soft reset pulse wrong");
endmodule
bind psr_phy_status_irq_regs psr_phy_status_irq_regs_sva psr_phy_status_irq_regs_sva_inst (
  .CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PHY_STAT(PHY_STAT),
  .PHY_CTRL(PHY_CTRL), .IRQ(IRQ));

// [tb/psr_phy_model.sv]
// Model of the PHY datapath that drives the live status indications
`timescale 1ns/100ps
module psr_phy_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire psr_pkg::psr_phy_stat_s want,
  output psr_pkg::psr_phy_stat_s stat
);
  // Indications move only just after an edge, as the datapath registers them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat <= '0;
    end else begin
      stat <= want;
    end
  end
endmodule

// [tb/psr_phy_status_irq_regs_tb.sv]
// Testbench of the PHY status and interrupt register block
`timescale 1ns/100ps
module psr_phy_status_irq_regs_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, er;
  psr_pkg::psr_phy_stat_s want = '0;
  psr_pkg::psr_phy_stat_s stat;
  psr_pkg::psr_phy_ctrl_s ctrl;
  int err_total = 0;
  int compares = 0;
  always #5 clk = ~clk;
  psr_phy_status_irq_regs psr_phy_status_irq_regs_inst (.CLK(clk), .ARST_N(arst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PHY_STAT(stat), .PHY_CTRL(ctrl), .IRQ(irq));
  psr_phy_model psr_phy_model_inst (.clk(clk), .arst_n(arst_n), .want(want), .stat(stat));
  task automatic final_report();
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rdc(12'h018, 32'h4);
    rdc(12'h040, 32'h60);
    rdc(12'h044, 32'h0);
    rdc(12'h048, 32'h0);
    rdc(12'h04C, 32'h0);
    chk(32'(ctrl.mdi_mode), 32'h3);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 12'h044, 32'hFFFF);
    rdc(12'h044, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h040, {22'h0, i[1:0], 8'h27});
      repeat (2) @(posedge clk);
      chk(32'(ctrl.ed_sense_en), 32'(i / 2));
      chk(32'(ctrl.nlp_tx_en), 32'(i == 3));
      chk(32'(ctrl.jabber_en), 32'h0);
    end
    chk(32'(ctrl.mdi_mode), 32'h3);
    chk(32'(ctrl.pol_correct_en), 32'h0);
    apb(1'b1, 12'h018, 32'h0);
    rdc(12'h018, 32'h0);
    apb(1'b1, 12'h07C, 32'h1);
    repeat (3) @(posedge clk);
    chk(32'(ctrl.mdi_mode), 32'h1);
    rdc(12'h018, 32'h4);
    rdc(12'h040, 32'h0327);
    apb(1'b1, 12'h040, 32'h0024);
    repeat (2) @(posedge clk);
    chk(32'(ctrl.pol_correct_en), 32'h1);
    apb(1'b1, 12'h048, 32'hFFFF);
    rdc(12'h048, 32'hFFF3);
    want.an_complete <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'(ctrl.sqe_test_en), 32'h1);
    chk(32'(ctrl.jabber_en), 32'h1);
    chk(32'(irq), 32'h1);
    want.full_duplex <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'(ctrl.sqe_test_en), 32'h0);
    chk(32'(ctrl.jabber_en), 32'h0);
    // Resolved 100M full duplex, link up, page, pause, sleep, downgrade, reversed, jabber
    want <= 17'h02F7E;
    repeat (4) @(posedge clk);
    rdc(12'h044, 32'h7C7F);
    apb(1'b1, 12'h07C, 32'h1);
    rdc(12'h048, 32'hFFF3);
    rdc(12'h04C, 32'h7800);
    rdc(12'h04C, 32'h1800);
    apb(1'b1, 12'h048, 32'h0);
    rdc(12'h048, 32'h0);
    chk(32'(irq), 32'h0);
    want.par_det_fault <= 1'b1;
    want.page_rx <= 1'b1;
    want.lp_an_able <= 1'b1;
    @(posedge clk);
    want.par_det_fault <= 1'b0;
    want.page_rx <= 1'b0;
    repeat (2) @(posedge clk);
    rdc(12'h018, 32'h17);
    rdc(12'h018, 32'h5);
    rdc(12'h04C, 32'h9800);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rdc(12'h048, 32'h0);
    rdc(12'h04C, 32'h1800);
    want.mdix_auto <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(12'h044, 32'h7C7F);
    want.an_complete <= 1'b0;
    want.an_disabled <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(12'h044, 32'h7C7F);
    final_report();
  end
endmodule
